// *** pirl_checker.sv ***
// Port checker of the ingress rate limiter, bound to its top module.
`default_nettype none
module pirl_checker (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic PORT_FC_EN_IN,
  input wire logic FRAME_VALID_IN,
  input wire logic FRAME_DROP_OUT,
  input wire logic FLOW_CTRL_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  // A bus request of either kind.
  logic req;
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  property p_drop; FRAME_DROP_OUT |-> $past(FRAME_VALID_IN); endproperty
  a_drop: assert property (p_drop) else $error("drop without a frame");
  property p_fc;
    $rose(FLOW_CTRL_OUT) |-> $past(PORT_FC_EN_IN) && $past(FRAME_VALID_IN) && !FRAME_DROP_OUT;
  endproperty
  a_fc: assert property (p_fc) else $error("flow control without cause");
  property p_fc_off; !PORT_FC_EN_IN |=> !FLOW_CTRL_OUT; endproperty
  a_fc_off: assert property (p_fc_off) else $error("flow control while port pause off");
  property p_wait; req && !$past(req) |-> AVS_WAITREQUEST_OUT; endproperty
  a_wait: assert property (p_wait) else $error("no wait cycle");
  property p_ack; req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT; endproperty
  a_ack: assert property (p_ack) else $error("wait too long");
  property p_idle; !req |-> !AVS_WAITREQUEST_OUT; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_unmap;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN < 12'h403 |-> AVS_READDATA_OUT == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_top;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:7] == 25'h0;
  endproperty
  a_top: assert property (p_top) else $error("reserved bits set");
  property p_rst; $fell(RST_IN) |-> !FRAME_DROP_OUT && !FLOW_CTRL_OUT; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  c_drop: cover property (FRAME_DROP_OUT);
  c_fc: cover property ($rose(FLOW_CTRL_OUT));
  c_unmap: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN < 12'h403);
endmodule
bind pirl_top pirl_checker u_pirl_checker (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .PORT_FC_EN_IN(PORT_FC_EN_IN), .FRAME_VALID_IN(FRAME_VALID_IN),
  .FRAME_DROP_OUT(FRAME_DROP_OUT), .FLOW_CTRL_OUT(FLOW_CTRL_OUT));
`default_nettype wire

// *** pirl_pkg.sv ***
// Package with register map, field layout and rate constants of the ingress rate limiter.
`default_nettype none
package pirl_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] CFG_IDX = 12'h403;
  localparam logic [11:0] STAT_IDX = 12'h404;
  localparam logic [11:0] LIM0_IDX = 12'h410;
  localparam logic [11:0] LIM7_IDX = 12'h417;
  // Field positions of the configuration register.
  localparam int CFG_PORT_BIT = 6;
  localparam int CFG_PPS_BIT = 5;
  localparam int CFG_FC_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_IFG_BIT = 1;
  localparam int CFG_PRE_BIT = 0;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [6:0] LIM_RESET = 7'h00;
  // Frame class selections.
  localparam logic [1:0] MODE_ALL = 2'h0;
  localparam logic [1:0] MODE_BMF = 2'h1;
  localparam logic [1:0] MODE_BM = 2'h2;
  localparam logic [1:0] MODE_B = 2'h3;
  // Link speed encodings.
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Extra bytes per frame.
  localparam logic [15:0] IFG_BYTES = 16'h000c;
  localparam logic [15:0] PRE_BYTES = 16'h0008;
  // Measurement window and clock rate.
  localparam int WINDOW_MS = 125;
  localparam int CLK_MHZ = 250;
  localparam int WINDOW_CYCLES = WINDOW_MS * CLK_MHZ * 1000;
  // Allowances per window: bytes in bit mode, frames in packet mode.
  localparam logic [31:0] LINE_BPS_10 = 32'd156250;
  localparam logic [31:0] LINE_BPS_100 = 32'd1562500;
  localparam logic [31:0] LINE_BPS_1000 = 32'd15625000;
  localparam logic [31:0] LINE_PPS_10 = 32'd2400;
  localparam logic [31:0] LINE_PPS_100 = 32'd24000;
  localparam logic [31:0] LINE_PPS_1000 = 32'd240000;
  localparam logic [31:0] BPS_1M = 32'd15625;
  localparam logic [31:0] BPS_10M = 32'd156250;
  localparam logic [31:0] BPS_64K = 32'd1000;
  localparam logic [31:0] BPS_640K = 32'd10000;
  localparam logic [31:0] PPS_1K92 = 32'd240;
  localparam logic [31:0] PPS_19K2 = 32'd2400;
  localparam logic [31:0] PPS_64 = 32'd8;
  localparam logic [31:0] PPS_128 = 32'd16;
  localparam logic [31:0] PPS_640 = 32'd80;
  // Bus handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } pirl_bus_t;
endpackage
`default_nettype wire

// *** pirl_tb.sv ***
// Self-checking testbench of the ingress rate limiter.
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench import pirl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] adr = 12'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] spd = SPD_10;
  logic fcen = 1'b0;
  logic fv = 1'b0;
  logic [15:0] flen = 16'd64;
  logic [2:0] fpri = 3'h0;
  logic [2:0] fcls = 3'h0; // Broadcast, multicast, flooded.
  logic drop;
  logic fc;
  logic [31:0] r;
  int num_errors = 0;
  int n_tests = 0;
  int drops = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  // A short window keeps the refill test brief.
  pirl_top #(.WIN_CYCLES(3000)) u_pirl_top (.CORE_CLK_IN(clk), .RST_IN(rst),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .LINK_SPEED_IN(spd),
    .PORT_FC_EN_IN(fcen), .FRAME_VALID_IN(fv), .FRAME_LEN_IN(flen), .FRAME_PRIO_IN(fpri),
    .FRAME_BCAST_IN(fcls[2]), .FRAME_MCAST_IN(fcls[1]), .FRAME_FLOOD_IN(fcls[0]),
    .FRAME_DROP_OUT(drop), .FLOW_CTRL_OUT(fc));
  // Drop counter and hang guard.
  always @(posedge clk) begin
    cyc++;
    if (drop !== 1'b0) drops++;
    if (cyc == 40000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Called just after an edge; the request stands until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // One idle edge keeps the next request out of this time step.
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] cf, input logic [31:0] c0, input logic [31:0] c7);
    do_reset();
    bus(1'b1, CFG_IDX, {24'h0, cf});
    bus(1'b1, LIM0_IDX, c0);
    bus(1'b1, LIM7_IDX, c7);
  endtask
  // Frames arrive back to back; drops are counted after the last answer lands.
  task automatic burst(input int n, input int exp, input string nm);
    drops = 0;
    repeat (n) begin
      @(posedge clk);
      fv <= 1'b1;
    end
    @(posedge clk);
    fv <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(nm, exp, drops)
  endtask
  task automatic t_regs();
    setup(8'hff, 32'hff, 32'h0);
    bus(1'b0, CFG_IDX, 32'h0);
    `CHK("cfg", 32'h7f, r)
    bus(1'b0, LIM0_IDX, 32'h0);
    `CHK("lim0", 32'h7f, r)
    bus(1'b0, 12'h000, 32'h0);
    `CHK("unmapped", 32'h0, r)
    do_reset();
    bus(1'b0, CFG_IDX, 32'h0);
    `CHK("cfg reset", 32'h0, r)
    bus(1'b0, LIM0_IDX, 32'h0);
    `CHK("lim0 reset", 32'h0, r)
  endtask
  // Code 101 is staged only; line rate stays until the priority 7 write.
  task automatic t_commit();
    setup(8'h21, 32'h0, 32'h0);
    bus(1'b1, LIM0_IDX, 32'h65);
    burst(9, 0, "staged");
    bus(1'b1, LIM7_IDX, 32'h0);
    burst(1, 1, "committed");
  endtask
  task automatic t_bytes();
    logic [7:0] cf [4] = '{8'h00, 8'h02, 8'h01, 8'h21};
    int dr [4] = '{1, 2, 2, 0};
    flen <= 16'd496;
    for (int i = 0; i < 4; i++) begin
      setup(cf[i], 32'h65, 32'h65);
      burst(3, dr[i], "bytes");
    end
    flen <= 16'd64;
  endtask
  // Rate codes across bands and speeds; bit-mode entries use 65535-byte frames.
  task automatic t_speed();
    logic [1:0] sp [10] = '{SPD_10, SPD_100, SPD_1000, SPD_10, SPD_100, SPD_1000, SPD_100,
                            SPD_1000, SPD_10, SPD_1000};
    logic [31:0] cd [10] = '{32'h65, 32'h65, 32'h65, 32'h01, 32'h02, 32'h67, 32'h0b, 32'h0b,
                             32'h64, 32'h00};
    logic [7:0] cf [10] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20,
                            8'h00, 8'h00, 8'h00, 8'h00};
    int np [10] = '{8, 8, 80, 240, 480, 320, 2, 26, 2, 238};
    for (int i = 0; i < 10; i++) begin
      spd <= sp[i];
      flen <= cf[i][5] ? 16'd64 : 16'hffff;
      setup(cf[i], cd[i], cd[i]);
      burst(np[i] + 1, 1, "rate");
    end
    spd <= SPD_10;
    flen <= 16'd64;
  endtask
  task automatic t_class();
    logic [2:0] ct [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [2:0] uc [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
    for (int m = 0; m < 4; m++) begin
      setup({4'h2, m[1:0], 2'h0}, 32'h65, 32'h65);
      if (m > 0) begin
        fcls <= uc[m];
        burst(9, 0, "uncounted");
      end
      fcls <= ct[m];
      burst(9, 1, "counted");
    end
    fcls <= 3'h0;
  endtask
  task automatic t_port();
    fpri <= 3'h7;
    setup(8'h60, 32'h65, 32'h0);
    burst(9, 1, "port");
    setup(8'h20, 32'h65, 32'h0);
    burst(9, 0, "priority");
    fpri <= 3'h0;
  endtask
  // Flow control admits the excess; without it the excess drops until the window refills.
  task automatic t_fc();
    fcen <= 1'b1;
    setup(8'h30, 32'h65, 32'h65);
    burst(9, 0, "fc admit");
    `CHK("fc", 1'b1, fc)
    bus(1'b0, STAT_IDX, 32'h0);
    `CHK("status", 32'h3, r)
    fcen <= 1'b0;
    burst(1, 1, "fc port off");
    `CHK("fc port off", 1'b0, fc)
    fcen <= 1'b1;
    setup(8'h20, 32'h65, 32'h65);
    burst(9, 1, "no fc");
    `CHK("fc off", 1'b0, fc)
    repeat (3000) @(posedge clk);
    burst(1, 0, "refill");
  endtask
  initial begin
    t_regs();
    t_commit();
    t_bytes();
    t_speed();
    t_class();
    t_port();
    t_fc();
    finish_test();
  end
endmodule
`default_nettype wire

// *** pirl_top.sv ***
// Ingress rate limiter of one switch port with its Avalon-MM register slave.
// Notes on behaviour
// R1: Mode bit set: one port limit; clear: per-priority.
// R2: PPS bit chooses packet or bit accounting.
// R3: Over limit asserts flow control when both enabled.
// R4: Two-bit field picks counted frame classes.
// R5: IFG option adds twelve bytes per frame.
// R6: Preamble option adds eight bytes per frame.
// R7: Preamble option ignored in packet mode.
// R8: Priority 0 limit: 7-bit code, resets zero.
// R9: Limit codes staged; priority 7 write commits all.
// R10: Code zero means full line rate.
// R11: Codes 1-10 scale per speed table.
// R12: Codes 11-100 scale at 100M and 1000M.
// R13: Codes 11-100 at 10M stay line rate.
// R14: Codes 101-115 use fixed low-rate table.
// R15: Excess dropped without flow control; windowed counting.
//
// Decided for this implementation: the Avalon-MM register port.
`default_nettype none
module pirl_top
  import pirl_pkg::*;
#(
  parameter int WIN_CYCLES = WINDOW_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Frame side: link speed, port pause enable and one frame per valid cycle.
  input wire logic [1:0] LINK_SPEED_IN,
  input wire logic PORT_FC_EN_IN,
  input wire logic FRAME_VALID_IN,
  input wire logic [15:0] FRAME_LEN_IN,
  input wire logic [2:0] FRAME_PRIO_IN,
  input wire logic FRAME_BCAST_IN,
  input wire logic FRAME_MCAST_IN,
  input wire logic FRAME_FLOOD_IN,
  output logic FRAME_DROP_OUT,
  output logic FLOW_CTRL_OUT
);

  // Turns a rate code into the allowance for one window.
  // Allowances are counted per window rather than per second, so each table entry is
  // pre-scaled by the window length; a shorter window in simulation keeps the same codes
  // but refills sooner.
  function automatic logic [31:0] allow_f(input logic [6:0] c, input logic [1:0] sp,
                                          input logic pps);
    logic [31:0] k;
    logic [31:0] r;
    k = {25'h0, c};
    r = 32'h0;
    if (c == 7'h00 || c > 7'h73) begin
      // Undefined high codes fall back to line rate rather than blocking traffic.
      case (sp)
        SPD_10: r = pps ? LINE_PPS_10 : LINE_BPS_10;
        SPD_100: r = pps ? LINE_PPS_100 : LINE_BPS_100;
        default: r = pps ? LINE_PPS_1000 : LINE_BPS_1000;
      endcase
    end else if (c <= 7'h0a) begin
      // Lowest band: one megabit step per code at every speed in bit mode; the packet step is ten times larger at 1000M.
      if (pps) begin
        r = (sp == SPD_10 || sp == SPD_100) ? PPS_1K92 * k : PPS_19K2 * k;
      end else begin
        r = BPS_1M * k;
      end
    end else if (c <= 7'h64) begin
      // Middle band: the slowest link has no finer setting and stays at line rate.
      case (sp)
        SPD_10: r = pps ? LINE_PPS_10 : LINE_BPS_10;
        SPD_100: r = pps ? PPS_1K92 * k : BPS_1M * k;
        default: r = pps ? PPS_19K2 * k : BPS_10M * k;
      endcase
    end else begin
      // Fixed low rates are indexed from one, so code 101 is step one.
      k = k - 32'd100;
      if (pps) begin
        if (sp == SPD_10 || sp == SPD_100) begin
          r = (k <= 32'd2) ? PPS_64 * k : PPS_128 * (k - 32'd1);
        end else begin
          // The gigabit column is ten times the slower one, so it doubles from code 103 on.
          r = (k <= 32'd2) ? PPS_640 * k : PPS_640 * (k + k - 32'd2); // [R14]
        end
      end else begin
        case (sp)
          SPD_10: r = BPS_64K * k;
          SPD_100: r = (k <= 32'd3) ? BPS_640K * k : BPS_64K * k;
          default: r = BPS_640K * k;
        endcase
      end
    end
    return r;
  endfunction

  // Bus handshake state and the register file.
  pirl_bus_t bus_st;
  pirl_bus_t next_bus_st;
  logic [6:0] cfg;
  logic [6:0] next_cfg;
  logic [6:0] stage [8];
  logic [6:0] next_stage [8];
  logic [6:0] act [8];
  logic [6:0] next_act [8];
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic req;
  logic wr_go;
  logic [11:0] lim_off;
  // Sticky excess flag of the current window, also shown in the status register.
  logic over_any;

  // One wait cycle per access keeps the read path registered.
  // The cost is two cycles per access, which matters little for a configuration port.
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = req & (bus_st == BUS_IDLE);
  assign AVS_READDATA_OUT = rdata;
  assign wr_go = AVS_WRITE_IN & (bus_st == BUS_ACK);
  assign lim_off = AVS_ADDRESS_IN - LIM0_IDX;

  // Bus handshake and register next values.
  always_comb begin
    next_bus_st = BUS_IDLE;
    case (bus_st)
      BUS_IDLE: next_bus_st = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK: next_bus_st = BUS_IDLE;
      default: next_bus_st = BUS_IDLE;
    endcase
    next_cfg = cfg;
    next_stage = stage;
    next_act = act;
    next_rdata = rdata;
    if (wr_go) begin
      if (AVS_ADDRESS_IN == CFG_IDX) begin
        next_cfg = AVS_WRITEDATA_IN[6:0];
      end else if (AVS_ADDRESS_IN >= LIM0_IDX && AVS_ADDRESS_IN <= LIM7_IDX) begin
        // Bit 7 stays reserved, so only the code is kept. [R8]
        next_stage[lim_off[2:0]] = AVS_WRITEDATA_IN[6:0];
      end
      if (AVS_ADDRESS_IN == LIM7_IDX) begin
        // The last priority write publishes every staged code together. [R9]
        // Software must finish staging before this write; later stagings wait again.
        next_act = next_stage;
      end
    end
    if (AVS_READ_IN && bus_st == BUS_IDLE) begin
      // Unmapped addresses read as zero.
      // The status word is a local addition: bit 0 flow control, bit 1 excess seen.
      next_rdata = 32'h0;
      if (AVS_ADDRESS_IN == CFG_IDX) begin
        next_rdata = {25'h0, cfg};
      end else if (AVS_ADDRESS_IN == STAT_IDX) begin
        next_rdata = {30'h0, over_any, FLOW_CTRL_OUT};
      end else if (AVS_ADDRESS_IN >= LIM0_IDX && AVS_ADDRESS_IN <= LIM7_IDX) begin
        next_rdata = {25'h0, stage[lim_off[2:0]]};
      end
    end
  end

  // Registers for the bus side.
  // Staged and active codes both reset to line rate.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_st <= BUS_IDLE;
      cfg <= CFG_RESET;
      rdata <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        stage[i] <= LIM_RESET; // [R8]
        act[i] <= LIM_RESET;
      end
    end else begin
      bus_st <= next_bus_st;
      cfg <= next_cfg;
      rdata <= next_rdata;
      stage <= next_stage;
      act <= next_act;
    end
  end

  // Frame side: classification, charge and the per-bucket accounting.
  logic port_mode;
  logic pps_mode;
  logic [1:0] cls_mode;
  logic counted;
  logic [2:0] bkt;
  logic [15:0] amount;
  logic [31:0] limit;
  logic [31:0] used [8];
  logic [31:0] cur;
  logic exceed;
  logic fc_allow;
  logic admit;
  logic [31:0] win_cnt;
  logic [31:0] next_win_cnt;
  logic tick;
  logic next_over_any;
  logic next_drop;
  logic next_fc;

  // Configuration fields decoded once for the frame logic.
  assign port_mode = cfg[CFG_PORT_BIT];
  assign pps_mode = cfg[CFG_PPS_BIT];
  assign cls_mode = cfg[CFG_MODE_LSB +: 2];

  // Frame class filter picks which frames are charged at all.
  // Frames outside the class are neither charged nor dropped.
  always_comb begin
    case (cls_mode)
      MODE_ALL: counted = 1'b1; // [R4]
      MODE_BMF: counted = FRAME_BCAST_IN | FRAME_MCAST_IN | FRAME_FLOOD_IN; // [R4]
      MODE_BM: counted = FRAME_BCAST_IN | FRAME_MCAST_IN; // [R4]
      MODE_B: counted = FRAME_BCAST_IN; // [R4]
      default: counted = 1'b1;
    endcase
  end

  // Port mode charges the single priority 0 bucket. [R1]
  // Priority mode charges the bucket of the frame's own priority.
  assign bkt = port_mode ? 3'h0 : FRAME_PRIO_IN;
  assign limit = allow_f(act[bkt], LINK_SPEED_IN, pps_mode); // [R10] [R11] [R12] [R13] [R14]
  assign cur = used[bkt];

  // Charge per frame; preamble only matters when counting bits.
  // A frame longer than 65515 bytes with both extras would wrap the 16-bit charge.
  always_comb begin
    if (pps_mode) begin
      amount = 16'h0001; // [R2] [R7]
    end else begin
      amount = FRAME_LEN_IN; // [R2]
      if (cfg[CFG_IFG_BIT]) begin
        amount = amount + IFG_BYTES; // [R5]
      end
      if (cfg[CFG_PRE_BIT]) begin
        amount = amount + PRE_BYTES; // [R6]
      end
    end
  end

  // A frame that would push the bucket past its allowance is over the limit.
  // Excess frames are charged only under flow control, so a dropped frame leaves room for a smaller one.
  assign exceed = FRAME_VALID_IN & counted & (cur + {16'h0, amount} > limit);
  assign fc_allow = cfg[CFG_FC_BIT] & PORT_FC_EN_IN; // [R3]
  // With flow control the frame is still accepted and the sender is paused.
  assign admit = FRAME_VALID_IN & counted & (~exceed | fc_allow); // [R15]
  assign tick = (win_cnt == 32'(WIN_CYCLES - 1));

  // Window timer and outcome flags.
  // Flow control follows the latest excess and falls as soon as either enable drops.
  always_comb begin
    next_win_cnt = tick ? 32'h0 : win_cnt + 32'h1; // [R15]
    next_drop = exceed & ~fc_allow; // [R15]
    next_fc = FLOW_CTRL_OUT;
    next_over_any = over_any;
    if (tick) begin
      next_fc = 1'b0;
      next_over_any = 1'b0;
    end
    // A new excess in the clearing cycle still sets the flags.
    if (exceed) begin
      next_fc = fc_allow; // [R3]
      next_over_any = 1'b1;
    end
    if (!fc_allow) begin
      next_fc = 1'b0; // [R3]
    end
  end

  // Registers for the window and outcomes.
  // The drop pulse is registered, so it trails its frame by exactly one cycle.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      win_cnt <= 32'h0;
      FRAME_DROP_OUT <= 1'b0;
      FLOW_CTRL_OUT <= 1'b0;
      over_any <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      FRAME_DROP_OUT <= next_drop;
      FLOW_CTRL_OUT <= next_fc;
      over_any <= next_over_any;
    end
  end

  // One usage counter per priority bucket, cleared at each window edge.
  // In port mode only bucket 0 is charged; the others hold their count until the window edge clears it.
  for (genvar g = 0; g < 8; g++) begin : g_bkt
    logic [31:0] next_used;
    always_comb begin
      next_used = tick ? 32'h0 : used[g]; // [R15]
      if (admit && bkt == 3'(g)) begin
        next_used = next_used + {16'h0, amount};
      end
    end
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        used[g] <= 32'h0;
      end else begin
        used[g] <= next_used;
      end
    end
  end

endmodule
`default_nettype wire
